// [hw/pst_cfg.svh]
// constants of the smbus target: timing, addresses, idle values
// assumes a 20 MHz core clock and open-drain pads with pull-ups
`ifndef PST_CFG_SVH
`define PST_CFG_SVH

// ----------------------------------------------------------------
// clock and link timing
// ----------------------------------------------------------------
`define PST_CLK_PERIOD_NS   50
`define PST_NS_PER_MS       1000000
`define PST_STRETCH_MAX_MS  1
`define PST_SCL_TIMEOUT_MS  25
`define PST_RECOVER_MS      10

// ----------------------------------------------------------------
// address bytes and fixed values
// ----------------------------------------------------------------
`define PST_CTL_BASE        8'hB0
`define PST_EEP_BASE        8'hA0
`define PST_TX_FILL         8'hFF
`define PST_BITS_PER_BYTE   4'h8
`define PST_PIN_IDLE        1'h1

`endif

// [hw/pst_pkg.sv]
// types shared by the smbus target and its bench
// assumes pst_cfg.svh for the numeric constants
package pst_pkg;

  // ----------------------------------------------------------------
  // receive / transmit sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_ACK,
    ST_TX_WAIT,
    ST_TX,
    ST_TX_ACK
  } pst_state_t;

  // ----------------------------------------------------------------
  // fault events from the supply controller
  // ----------------------------------------------------------------
  typedef struct packed {
    logic temp_warn;
    logic fan_slow;
    logic temp_shut;
    logic gen_fail;
    logic over_curr;
    logic over_volt;
    logic under_volt;
    logic fan_fail;
  } pst_events_t;

  // ----------------------------------------------------------------
  // raw pin group, sampled together
  // ----------------------------------------------------------------
  typedef struct packed {
    logic scl;
    logic sda;
    logic strap_reused;
    logic strap2;
    logic strap1;
    logic strap0;
  } pst_pins_t;

endpackage

// [hw/pst_sync3.sv]
// three-stage input synchroniser with agreement filter
// assumes inputs asynchronous to clk, idle level high
`timescale 1ns/1ps
`default_nettype none
`include "pst_cfg.svh"

module pst_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  // ----------------------------------------------------------------
  // one chain per bit; value moves when stages two and three agree
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        s1   <= `PST_PIN_IDLE;
        s2   <= `PST_PIN_IDLE;
        s3   <= `PST_PIN_IDLE;
        q[i] <= `PST_PIN_IDLE;
      end
      else
      begin
        s1 <= d[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3)
        begin
          q[i] <= s3;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [hw/pst_smbus_target.sv]
// smbus target interface of the supply with strap addressing and alert
// assumes open-drain pads resolved outside; core_clk 20 MHz; scl is
// sampled, never used as a clock
`timescale 1ns/1ps
`default_nettype none
`include "pst_cfg.svh"

module pst_smbus_target #(
  parameter int STRETCH_CYC = (`PST_STRETCH_MAX_MS * `PST_NS_PER_MS)
                              / `PST_CLK_PERIOD_NS,
  parameter int TIMEOUT_CYC = (`PST_SCL_TIMEOUT_MS * `PST_NS_PER_MS
                              + `PST_CLK_PERIOD_NS - 1) / `PST_CLK_PERIOD_NS
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               scl_in,
  output var  logic               scl_out,
  output var  logic               scl_oe,
  input  wire logic               sda_in,
  output var  logic               sda_out,
  output var  logic               sda_oe,
  input  wire logic               addr_strap_bit0,
  input  wire logic               addr_strap_bit1,
  input  wire logic               addr_strap_bit2,
  input  wire logic               strap2_reused,
  input  wire pst_pkg::pst_events_t events,
  output var  logic               fault_alert_n,
  output var  logic               fault_alert_oe,
  output var  logic               led_amber_solid,
  output var  logic               led_amber_blink,
  output var  logic [7:0]         rx_data,
  output var  logic               rx_valid,
  output var  logic               rx_first,
  output var  logic               xfer_eeprom,
  input  wire logic [7:0]         tx_data,
  input  wire logic               tx_valid,
  output var  logic               tx_taken,
  output var  logic               bus_busy,
  output var  logic               bus_timeout
);
  import pst_pkg::*;

  pst_pins_t   pins_raw;
  pst_pins_t   pins;
  pst_state_t  state;
  logic        scl_q;
  logic        sda_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic [7:0]  ctl_addr;
  logic [7:0]  eep_addr;
  logic [7:0]  sh;
  logic [3:0]  bit_cnt;
  logic        rd;
  logic        nack;
  logic        first;
  logic        hit_ctl;
  logic        hit_eep;
  logic [15:0] stretch_cnt;
  logic        stretch_hit;
  logic [19:0] low_cnt;
  logic        timeout_hit;
  logic [7:0]  tx_byte;
  logic        ev_shut;
  logic        ev_warn;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  assign pins_raw = '{scl: scl_in, sda: sda_in,
                      strap_reused: strap2_reused,
                      strap2: addr_strap_bit2,
                      strap1: addr_strap_bit1,
                      strap0: addr_strap_bit0};

  pst_sync3 #(
    .W ($bits(pst_pins_t))
  ) u_sync (
    .clk (core_clk),
    .rst (rst),
    .d   (pins_raw),
    .q   (pins)
  );

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_q   <= `PST_PIN_IDLE;
      sda_q   <= `PST_PIN_IDLE;
      scl_out <= 1'h0;
      sda_out <= 1'h0;
    end
    else
    begin
      scl_q   <= pins.scl;
      sda_q   <= pins.sda;
      scl_out <= 1'h0;
      sda_out <= 1'h0;
    end
  end

  assign scl_rise  = pins.scl & ~scl_q;
  assign scl_fall  = ~pins.scl & scl_q;
  // start and stop are sda edges while scl stays high
  assign start_det = scl_q & pins.scl & sda_q & ~pins.sda;
  assign stop_det  = scl_q & pins.scl & ~sda_q & pins.sda;

  // ----------------------------------------------------------------
  // address formation from straps
  // ----------------------------------------------------------------
  // open pads read high by the pad pull-up, grounded pads low
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctl_addr <= `PST_CTL_BASE;
      eep_addr <= `PST_EEP_BASE;
    end
    else
    begin
      ctl_addr <= `PST_CTL_BASE + {4'h0, pins.strap2 & ~pins.strap_reused,
                  pins.strap1, pins.strap0, 1'h0};
      eep_addr <= `PST_EEP_BASE + {4'h0, pins.strap2 & ~pins.strap_reused,
                  pins.strap1, pins.strap0, 1'h0};
    end
  end

  assign hit_ctl = sh[7:1] == ctl_addr[7:1];
  assign hit_eep = sh[7:1] == eep_addr[7:1];
  assign tx_byte = tx_valid ? tx_data : `PST_TX_FILL;

  // ----------------------------------------------------------------
  // stretch and timeout counters
  // ----------------------------------------------------------------
  assign stretch_hit = stretch_cnt == 16'(STRETCH_CYC - 2);
  assign timeout_hit = low_cnt == 20'(TIMEOUT_CYC - 1);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      stretch_cnt <= 16'h0000;
    end
    else
    begin
      stretch_cnt <= scl_oe ? stretch_cnt + 16'h0001 : 16'h0000;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      low_cnt <= 20'h00000;
    end
    else if (!pins.scl && state != ST_IDLE && !timeout_hit)
    begin
      low_cnt <= low_cnt + 20'h00001;
    end
    else
    begin
      low_cnt <= 20'h00000;
    end
  end

  // ----------------------------------------------------------------
  // byte sequencer
  // ----------------------------------------------------------------
  // sda and scl are only ever pulled low while scl is low inside a
  // transfer the host opened, so no start is ever produced here
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state       <= ST_IDLE;
      sh          <= 8'h00;
      bit_cnt     <= 4'h0;
      rd          <= 1'h0;
      nack        <= 1'h0;
      first       <= 1'h0;
      sda_oe      <= 1'h0;
      scl_oe      <= 1'h0;
      rx_data     <= 8'h00;
      rx_valid    <= 1'h0;
      rx_first    <= 1'h0;
      xfer_eeprom <= 1'h0;
      tx_taken    <= 1'h0;
      bus_busy    <= 1'h0;
      bus_timeout <= 1'h0;
    end
    else
    begin
      rx_valid    <= 1'h0;
      tx_taken    <= 1'h0;
      bus_timeout <= 1'h0;
      if (start_det)
      begin
        state    <= ST_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe   <= 1'h0;
        scl_oe   <= 1'h0;
        bus_busy <= 1'h1;
      end
      else if (stop_det)
      begin
        state    <= ST_IDLE;
        sda_oe   <= 1'h0;
        scl_oe   <= 1'h0;
        bus_busy <= 1'h0;
      end
      else if (timeout_hit)
      begin
        state       <= ST_IDLE;
        sda_oe      <= 1'h0;
        scl_oe      <= 1'h0;
        bus_busy    <= 1'h0;
        bus_timeout <= 1'h1;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            sda_oe <= 1'h0;
            scl_oe <= 1'h0;
          end
          ST_ADDR, ST_RX:
          begin
            if (scl_rise)
            begin
              sh      <= {sh[6:0], pins.sda};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == `PST_BITS_PER_BYTE)
            begin
              if (state == ST_RX)
              begin
                sda_oe   <= 1'h1;
                rx_data  <= sh;
                rx_valid <= 1'h1;
                rx_first <= first;
                first    <= 1'h0;
                state    <= ST_RX_ACK;
              end
              else if (hit_ctl || hit_eep)
              begin
                sda_oe      <= 1'h1;
                xfer_eeprom <= hit_eep;
                rd          <= sh[0];
                first       <= 1'h1;
                state       <= ST_ADDR_ACK;
              end
              else
              begin
                state    <= ST_IDLE;
                bus_busy <= 1'h0;
              end
            end
          end
          ST_ADDR_ACK, ST_RX_ACK:
          begin
            if (scl_fall)
            begin
              sda_oe  <= 1'h0;
              bit_cnt <= 4'h0;
              state   <= (state == ST_ADDR_ACK && rd) ? ST_TX_WAIT : ST_RX;
            end
          end
          ST_TX_WAIT:
          begin
            scl_oe <= 1'h1;
            if (tx_valid || stretch_hit)
            begin
              sh       <= tx_byte;
              sda_oe   <= ~tx_byte[7];
              tx_taken <= tx_valid;
              bit_cnt  <= 4'h1;
              state    <= ST_TX;
            end
          end
          ST_TX:
          begin
            scl_oe <= 1'h0;
            if (scl_fall)
            begin
              if (bit_cnt == `PST_BITS_PER_BYTE)
              begin
                sda_oe <= 1'h0;
                state  <= ST_TX_ACK;
              end
              else
              begin
                sh      <= {sh[6:0], 1'h0};
                sda_oe  <= ~sh[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_TX_ACK:
          begin
            if (scl_rise)
            begin
              nack <= pins.sda;
            end
            else if (scl_fall)
            begin
              state <= nack ? ST_IDLE : ST_TX_WAIT;
            end
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // fault alert and amber indication
  // ----------------------------------------------------------------
  assign ev_shut = events.temp_shut | events.gen_fail | events.over_curr |
                   events.over_volt | events.under_volt | events.fan_fail;
  assign ev_warn = events.temp_warn | events.fan_slow;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fault_alert_n   <= 1'h1;
      fault_alert_oe  <= 1'h0;
      led_amber_solid <= 1'h0;
      led_amber_blink <= 1'h0;
    end
    else
    begin
      fault_alert_n   <= ~(ev_shut | ev_warn);
      fault_alert_oe  <= ev_shut | ev_warn;
      led_amber_solid <= ev_shut;
      led_amber_blink <= ev_warn & ~ev_shut;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_stretch_bound: assert property (
    scl_oe |-> stretch_cnt < 16'(STRETCH_CYC))
    else $error("scl held low too long");
  chk_timeout_abort: assert property (
    timeout_hit && !start_det && !stop_det |=>
      state == ST_IDLE && !sda_oe && !scl_oe && bus_timeout)
    else $error("timeout did not abandon transfer");
  chk_start_resync: assert property (
    start_det |=> state == ST_ADDR && bit_cnt == 4'h0 && !sda_oe)
    else $error("start did not resync receiver");
  chk_stop_release: assert property (
    stop_det |=> state == ST_IDLE && !sda_oe ##1 !sda_oe)
    else $error("stop did not release bus");
  chk_no_start: assert property (
    $rose(sda_oe) |-> !pins.scl && state != ST_IDLE)
    else $error("sda pulled low outside scl low");
  chk_ack_match: assert property (
    state == ST_ADDR && scl_fall && bit_cnt == 4'h8 && !start_det &&
      !stop_det && !timeout_hit |=> sda_oe == $past(hit_ctl || hit_eep))
    else $error("address acknowledge wrong");
  chk_addr_offset: assert property (
    ctl_addr - eep_addr == 8'h10 && ctl_addr[0] == 1'h0)
    else $error("address pair malformed");
  chk_strap2_forced: assert property (
    pins.strap_reused && $stable(pins) |=> ctl_addr[3] == 1'h0)
    else $error("third address bit not forced");
  chk_alert_events: assert property (
    (ev_shut || ev_warn) |=> fault_alert_oe && !fault_alert_n)
    else $error("alert missing for event");
  chk_alert_clear: assert property (
    !(ev_shut || ev_warn) |=> !fault_alert_oe && fault_alert_n)
    else $error("alert without event");
  chk_alert_led: assert property (
    fault_alert_oe == (led_amber_solid || led_amber_blink))
    else $error("alert and amber out of step");

  cov_write_byte: cover property (rx_valid && !rx_first);
  cov_read_byte:  cover property (state == ST_TX_ACK && scl_rise);
  cov_stretch:    cover property (scl_oe ##1 !scl_oe);
  cov_timeout:    cover property (bus_timeout);

endmodule
`default_nettype wire

// [bench/pst_host.sv]
// smbus host model: start, stop, bit and byte transfers
// assumes a wired-and bus resolved in the bench with pull-ups to high
`timescale 1ns/1ps
`default_nettype none

module pst_host #(
  parameter int QTR     = 2,
  parameter int BUF_CYC = 20
) (
  input  wire logic core_clk,
  input  wire logic scl_bus,
  input  wire logic sda_bus,
  output var  logic scl_drv,
  output var  logic sda_drv,
  output var  logic hung
);
  initial
  begin
    scl_drv = 1'b0;
    sda_drv = 1'b0;
    hung    = 1'b0;
  end

  // ----------------------------------------------------------------
  // line timing
  // ----------------------------------------------------------------
  task automatic wait_q(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // release scl, wait out a target stretch
  task automatic scl_high();
    int i;
    scl_drv = 1'b0;
    @(negedge core_clk);
    for (i = 0; i < 1000 && scl_bus !== 1'b1; i++)
      @(negedge core_clk);
    if (i == 1000)
      hung = 1'b1;
  endtask

  // one bit: 8 core cycles, 400 ns period; scl low 5, high 3
  // long low phase leaves room for the target's synchroniser delay
  task automatic put_bit(input logic b, output logic s);
    wait_q(QTR);
    sda_drv = ~b;
    wait_q(QTR + 1);
    scl_high();
    wait_q(QTR - 1);
    s = sda_bus;
    wait_q(QTR - 1);
    scl_drv = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // conditions and bytes
  // ----------------------------------------------------------------
  // start from idle or repeated start from scl low
  task automatic start();
    wait_q(QTR);
    sda_drv = 1'b0;
    wait_q(QTR);
    scl_high();
    wait_q(QTR);
    sda_drv = 1'b1;
    wait_q(QTR);
    scl_drv = 1'b1;
  endtask

  task automatic stop();
    wait_q(QTR);
    sda_drv = 1'b1;
    wait_q(QTR);
    scl_high();
    wait_q(QTR);
    sda_drv = 1'b0;
    wait_q(BUF_CYC);
  endtask

  // msb first, returns ack bit (0 = ack)
  task automatic write_byte(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], ack_n);
    put_bit(1'b1, ack_n);
  endtask

  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(1'b1, d[i]);
    put_bit(nack, s);
  endtask
endmodule
`default_nettype wire

// [bench/psu_smbus_target_interface_test.sv]
// self-checking bench of the smbus target with a host model
// assumes pst_pkg, pst_cfg.svh and pst_host compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "pst_cfg.svh"

module psu_smbus_target_interface_test;
  import pst_pkg::*;
  localparam int STRETCH = 40;
  localparam int TMO     = 200;
  logic        core_clk, rst, scl_bus, sda_bus, scl_out, scl_oe;
  logic        sda_out, sda_oe, reused, rx_valid, rx_first, xfer_eeprom;
  logic        fault_alert_n, fault_alert_oe, led_amber_solid;
  logic        led_amber_blink, tx_valid, tx_taken, bus_busy, bus_timeout;
  logic        scl_drv, sda_drv, hung, ak, rx_f;
  logic [2:0]  strap;
  logic [7:0]  rx_data, tx_data, rx_last, ev, q;
  logic [15:0] seed;
  pst_events_t events;
  int          error_cnt, num_checks, rx_cnt, tk_cnt, to_cnt, run, run_max;

  // ----------------------------------------------------------------
  // clock, bus, design and host
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  assign scl_bus = ~(scl_drv | (scl_oe & ~scl_out));
  assign sda_bus = ~(sda_drv | (sda_oe & ~sda_out));

  pst_smbus_target #(.STRETCH_CYC(STRETCH), .TIMEOUT_CYC(TMO)) dut (
    .core_clk(core_clk), .rst(rst), .scl_in(scl_bus), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
    .addr_strap_bit2(strap[2]), .strap2_reused(reused), .events(events),
    .fault_alert_n(fault_alert_n), .fault_alert_oe(fault_alert_oe),
    .led_amber_solid(led_amber_solid), .led_amber_blink(led_amber_blink),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_first(rx_first),
    .xfer_eeprom(xfer_eeprom), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_taken(tx_taken), .bus_busy(bus_busy), .bus_timeout(bus_timeout));

  pst_host host (
    .core_clk(core_clk), .scl_bus(scl_bus), .sda_bus(sda_bus),
    .scl_drv(scl_drv), .sda_drv(sda_drv), .hung(hung));

  // ----------------------------------------------------------------
  // monitors and helpers
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (rx_valid === 1'b1)
    begin
      rx_cnt++;
      rx_last = rx_data;
      rx_f = rx_first;
    end
    if (tx_taken === 1'b1)
      tk_cnt++;
    if (bus_timeout === 1'b1)
      to_cnt++;
    run = (scl_oe === 1'b1) ? run + 1 : 0;
    if (run > run_max)
      run_max = run;
  end

  always @(posedge hung)
  begin
    error_cnt++;
    end_of_test();
  end

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // address byte with direction in bit zero
  function automatic logic [7:0] adr(input logic eep, input logic [2:0] s,
                                     input logic reu, input logic rd);
    return (eep ? `PST_EEP_BASE : `PST_CTL_BASE)
           + {4'h0, s[2] & ~reu, s[1:0], rd};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // write one data byte, or expect the address refused
  task automatic xfer_w(input logic [7:0] a, input logic [7:0] d,
                        input logic ok, input logic eep);
    int c0;
    c0 = rx_cnt;
    host.start();
    host.write_byte(a, ak);
    check(ak, {~ok});
    if (ok)
    begin
      host.write_byte(d, ak);
      host.wait_q(4);
      check({8'(rx_cnt - c0), rx_last, rx_f, xfer_eeprom},
            {8'h01, d, 1'b1, eep});
    end
    else
    begin
      host.wait_q(6);
      check(bus_busy, 1'b0);
    end
    host.stop();
  endtask

  // read n bytes, with or without data on offer
  task automatic xfer_r(input logic [7:0] a, input logic have, input int n);
    int c0;
    c0 = tk_cnt;
    tx_data = seed[7:0];
    tx_valid = have;
    run_max = 0;
    host.start();
    host.write_byte(a | 8'h01, ak);
    check(ak, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      host.read_byte(i == n - 1, q);
      check(q, have ? tx_data : `PST_TX_FILL);
    end
    host.stop();
    tx_valid = 1'b0;
    check(tk_cnt - c0, have ? n : 0);
    check(run_max <= STRETCH, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    strap = 3'h7;
    reused = 1'b0;
    events = '0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    seed = 16'h432A;
    repeat (3) @(negedge core_clk);
    check({scl_oe, sda_oe, fault_alert_n, bus_busy}, 4'h2);
    @(negedge core_clk);
    rst = 1'b0;
    repeat (10) @(negedge core_clk);
    for (int i = 0; i < 12; i++)
    begin
      ev = (i < 8) ? (8'h01 << i) : ((i < 11) ? seed[7:0] : 8'h00);
      seed = nx(seed);
      events = pst_events_t'(ev);
      @(negedge core_clk);
      check({fault_alert_n, fault_alert_oe}, {~|ev, |ev});
      check({led_amber_solid, led_amber_blink},
            {|ev[5:0], ~|ev[5:0] & |ev[7:6]});
      check({scl_oe, sda_oe, bus_busy, scl_out, sda_out}, 5'h00);
    end
    $display("test alert done");
    for (int k = 0; k < 16; k++)
    begin
      strap = k[2:0];
      reused = k[3];
      repeat (10) @(negedge core_clk);
      xfer_w(adr(1'b0, strap, reused, 1'b0), seed[7:0], 1'b1, 1'b0);
      xfer_w(adr(1'b1, strap, reused, 1'b0), seed[15:8], 1'b1, 1'b1);
      xfer_w(adr(1'b0, strap, 1'b0, 1'b0), seed[7:0],
             ~(reused & strap[2]), 1'b0);
      xfer_w(adr(1'b0, strap, reused, 1'b0) ^ 8'h40, 8'h00, 1'b0, 1'b0);
      seed = nx(seed);
    end
    $display("test address done");
    xfer_r(adr(seed[0], strap, reused, 1'b0), 1'b1, 2);
    xfer_r(adr(1'b0, strap, reused, 1'b0), 1'b0, 1);
    $display("test read done");
    host.start();
    host.write_byte(adr(1'b0, strap, reused, 1'b0), ak);
    for (int i = 0; i < 3; i++)
      host.put_bit(1'b0, ak);
    xfer_w(adr(1'b1, strap, reused, 1'b0), 8'h5A, 1'b1, 1'b1);
    $display("test restart done");
    to_cnt = 0;
    host.start();
    host.write_byte(adr(1'b0, strap, reused, 1'b0), ak);
    host.put_bit(1'b1, ak);
    host.wait_q(TMO + 20);
    check({8'(to_cnt), bus_busy, scl_oe, sda_oe}, {8'h01, 3'h0});
    host.stop();
    xfer_w(adr(1'b0, strap, reused, 1'b0), 8'hC3, 1'b1, 1'b0);
    $display("test timeout done");
    end_of_test();
  end
endmodule
`default_nettype wire
